// >>> qrd_engine.sv
// Purpose: device-side quad read, burst wrap and continuous read
// Assumes: link pins slower than clk by at least 8x; array answers
//          each request with one rvalid a few cycles later
// Notes:   pins pass two flops; edges found on the synced copies
`timescale 1ns/1ns
module qrd_engine #(
	parameter int ADDR_W = 23,
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic                 cs_n,
	input  wire logic                 sclk,
	input  wire logic [3:0]           io_in,
	output logic      [3:0]           io_out,
	output logic      [3:0]           io_oe,
	input  wire logic                 busy,
	input  wire logic                 quad_command_mode,
	input  wire logic                 dummy_count_bit_lo,
	input  wire logic                 dummy_count_bit_hi,
	output logic                      mem_req,
	input  wire logic                 mem_ready,
	output logic      [ADDR_W-1:0]    mem_addr,
	input  wire logic                 mem_rvalid,
	input  wire logic [7:0]           mem_rdata,
	output logic                      xip_active,
	output logic                      wrap_enabled,
	output logic      [1:0]           wrap_depth_code
);
	import qrd_pkg::*;

	initial begin
		if (ADDR_W < 7 || ADDR_W > 24)
			$error("address width must be 7..24");
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// next byte address, wrapping inside the aligned block if asked
	function automatic logic [ADDR_W-1:0] step_addr(
		input logic [ADDR_W-1:0] a, input logic wr, input logic [1:0] d);
		logic [ADDR_W-1:0] m;
		m = (ADDR_W'(6'h07) << d) | ADDR_W'(6'h07); // low bits always wrap
		step_addr = wr ? ((a & ~m) | ((a + 1'b1) & m)) : a + 1'b1; // RL2 RL12
	endfunction : step_addr

	// dummy clocks for a command, configuration bits override
	function automatic logic [3:0] dummy_clocks(
		input logic [1:0] dc, input logic [3:0] dflt);
		unique case (dc) // RL7
			2'b00: dummy_clocks = dflt;
			2'b01: dummy_clocks = DUMMY_DC_01;
			2'b10: dummy_clocks = DUMMY_DC_10;
			2'b11: dummy_clocks = DUMMY_DC_11;
		endcase
	endfunction : dummy_clocks

	// ------------------------------------------------------------
	// pin synchronisers and edge detect
	// ------------------------------------------------------------
	link_pins_t s1_r, s2_r, s3_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_r <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
			s2_r <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
			s3_r <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
		end else begin
			s1_r <= '{cs_n: cs_n, sclk: sclk, io: io_in};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	logic cs_fall, cs_rise, sclk_rise, sclk_fall;
	assign cs_fall   = s3_r.cs_n && !s2_r.cs_n;
	assign cs_rise   = !s3_r.cs_n && s2_r.cs_n;
	assign sclk_rise = !s2_r.cs_n && !s3_r.sclk && s2_r.sclk;
	assign sclk_fall = !s2_r.cs_n && s3_r.sclk && !s2_r.sclk;

	// ------------------------------------------------------------
	// frame state
	// ------------------------------------------------------------
	rd_state_t         st_r, st_nxt;
	logic [4:0]        cnt_r, cnt_nxt;
	logic [7:0]        sh_r, sh_nxt, op_r, op_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt, fa_r, fa_nxt;
	logic [3:0]        dcnt_r, dcnt_nxt, out_r, out_nxt, lo_r, lo_nxt;
	logic              quad_r, quad_nxt, half_r, half_nxt;
	logic              xip_r, xip_nxt, keep_r, keep_nxt, ind_r, ind_nxt;
	logic              wen_r, wen_nxt, fon_r, fon_nxt, pend_r, pend_nxt;
	logic              wact_r, wact_nxt;
	logic [1:0]        wdep_r, wdep_nxt, dc;
	logic [7:0]        byte_in, fifo_q;
	logic [23:0]       addr_in, addr_ext;
	logic              last, fifo_rdy, fifo_vld, pop, push;

	assign dc      = {dummy_count_bit_hi, dummy_count_bit_lo};
	// lines 3..1 are don't care while a serial byte comes in
	assign byte_in = quad_r ? {sh_r[3:0], s2_r.io}
	                        : {sh_r[6:0], s2_r.io[0]}; // RL14
	// widened first so a narrow array shifts its address the same way
	assign addr_ext = 24'(addr_r);
	assign addr_in = quad_r ? {addr_ext[19:0], s2_r.io}
	                        : {addr_ext[22:0], s2_r.io[0]};
	assign last    = (cnt_r == (quad_r ? QUAD_BYTE_LAST : SER_BYTE_LAST));

	// sequence of one frame, sampled on rising link edges
	always_comb begin
		st_nxt = st_r; cnt_nxt = cnt_r; sh_nxt = sh_r; op_nxt = op_r;
		addr_nxt = addr_r; dcnt_nxt = dcnt_r; quad_nxt = quad_r;
		xip_nxt = xip_r; keep_nxt = keep_r; ind_nxt = ind_r;
		wen_nxt = wen_r; wdep_nxt = wdep_r; fon_nxt = fon_r;
		wact_nxt = wact_r; half_nxt = half_r; out_nxt = out_r;
		lo_nxt = lo_r; pop = 1'b0;
		if (cs_rise) begin
			st_nxt = ST_IDLE;
			fon_nxt = 1'b0;
			if (ind_r)
				xip_nxt = keep_r; // RL17
		end else if (cs_fall) begin
			cnt_nxt = '0; sh_nxt = '0; half_nxt = 1'b0; ind_nxt = 1'b0;
			addr_nxt = '0;
			if (xip_r && !busy) begin
				st_nxt = ST_ADDR; // RL18
				op_nxt = OP_FOUR_LINE_IO_READ;
				quad_nxt = 1'b1;
			end else if (xip_r) begin
				st_nxt = ST_IGNORE; // RL6
			end else begin
				st_nxt = ST_CMD;
				quad_nxt = quad_command_mode; // RL5
			end
		end else if (sclk_rise) begin
			cnt_nxt = cnt_r + 5'h01; // RL1
			unique case (st_r)
				ST_CMD: begin
					sh_nxt = byte_in;
					if (last) begin
						cnt_nxt = '0;
						op_nxt = byte_in;
						st_nxt = ST_IGNORE;
						if (byte_in == OP_MODE_RESET)
							xip_nxt = 1'b0; // RL21
						if (busy)
							st_nxt = ST_IGNORE; // RL6
						else if (byte_in == OP_QUAD_OUTPUT_READ && !quad_r)
							st_nxt = ST_ADDR; // RL3
						else if (byte_in == OP_FOUR_LINE_IO_READ) begin
							st_nxt = ST_ADDR; // RL4 RL5
							quad_nxt = 1'b1;
						end else if (byte_in == OP_FOUR_LINE_READ_SHORT_DUMMY
						             && !quad_r) begin
							st_nxt = ST_ADDR; // RL8
							quad_nxt = 1'b1;
						end else if (byte_in == OP_SET_BURST)
							st_nxt = ST_WRAPB; // RL10
					end
				end
				ST_ADDR: begin
					addr_nxt = addr_in[ADDR_W-1:0];
					if (cnt_r == (quad_r ? QUAD_ADDR_LAST : SER_ADDR_LAST)) begin
						cnt_nxt = '0;
						fon_nxt = 1'b1;
						wact_nxt = wen_r && op_r != OP_QUAD_OUTPUT_READ; // RL13
						quad_nxt = 1'b1;
						if (op_r == OP_FOUR_LINE_IO_READ)
							st_nxt = ST_IND; // RL15
						else begin
							st_nxt = ST_DUMMY;
							dcnt_nxt = (op_r == OP_QUAD_OUTPUT_READ)
							    ? dummy_clocks(dc, DUMMY_QUAD_OUTPUT) // RL3
							    : DUMMY_SHORT; // RL8
						end
					end
				end
				ST_IND: begin
					sh_nxt = byte_in;
					if (cnt_r == IND_LAST) begin
						ind_nxt = 1'b1;
						keep_nxt = (byte_in[7:4] == ~byte_in[3:0]); // RL16 RL17
						st_nxt = ST_DUMMY; // RL19
						dcnt_nxt = dummy_clocks(dc, DUMMY_FOUR_LINE) - IND_CLOCKS;
					end
				end
				ST_DUMMY: begin
					dcnt_nxt = dcnt_r - 4'h1;
					if (dcnt_r == 4'h1)
						st_nxt = ST_DATA;
				end
				ST_WRAPB: begin
					sh_nxt = byte_in;
					if (last) begin
						st_nxt = ST_IGNORE;
						if (byte_in[WRAP_OFF_BIT])
							wen_nxt = 1'b0; // RL11
						else if (byte_in[7:2] == 6'h00) begin
							wen_nxt = 1'b1; // RL9 RL11
							wdep_nxt = byte_in[1:0];
						end
					end
				end
				default: cnt_nxt = cnt_r;
			endcase
		end else if (sclk_fall && st_r == ST_DATA) begin
			// high nibble first; an empty fifo repeats stale data
			half_nxt = !half_r;
			if (!half_r) begin
				out_nxt = fifo_q[7:4]; // RL1
				lo_nxt = fifo_q[3:0];
				pop = fifo_vld;
			end else
				out_nxt = lo_r;
		end
	end

	// fetch engine: one outstanding array read at a time
	always_comb begin
		fa_nxt = fa_r;
		pend_nxt = pend_r;
		mem_req = fon_r && !pend_r && fifo_rdy && !s2_r.cs_n;
		if (st_r == ST_ADDR && fon_nxt && !fon_r)
			fa_nxt = addr_nxt;
		if (mem_req && mem_ready) begin
			pend_nxt = 1'b1;
			fa_nxt = step_addr(fa_r, wact_r, wdep_r); // RL2 RL12
		end
		if (mem_rvalid || s2_r.cs_n)
			pend_nxt = 1'b0;
	end
	assign push = mem_rvalid && pend_r && !s2_r.cs_n;

	// controller reset clears both modes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= ST_IDLE; cnt_r <= '0; sh_r <= '0; op_r <= '0;
			addr_r <= '0; dcnt_r <= '0; quad_r <= 1'b0; half_r <= 1'b0;
			xip_r <= 1'b0; keep_r <= 1'b0; ind_r <= 1'b0; // RL22
			wen_r <= 1'b0; wdep_r <= WRAP_RESET_CODE; // RL9
			fon_r <= 1'b0; wact_r <= 1'b0; pend_r <= 1'b0; fa_r <= '0;
			out_r <= '0; lo_r <= '0;
		end else begin
			st_r <= st_nxt; cnt_r <= cnt_nxt; sh_r <= sh_nxt;
			op_r <= op_nxt; addr_r <= addr_nxt; dcnt_r <= dcnt_nxt;
			quad_r <= quad_nxt; half_r <= half_nxt; xip_r <= xip_nxt;
			keep_r <= keep_nxt; ind_r <= ind_nxt; wen_r <= wen_nxt;
			wdep_r <= wdep_nxt; fon_r <= fon_nxt; wact_r <= wact_nxt;
			pend_r <= pend_nxt; fa_r <= fa_nxt; out_r <= out_nxt;
			lo_r <= lo_nxt;
		end
	end

	qrd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk      (clk),
		.nrst     (nrst),
		.flush    (s2_r.cs_n),
		.in_valid (push),
		.in_ready (fifo_rdy),
		.in_data  (mem_rdata),
		.out_valid(fifo_vld),
		.out_ready(pop),
		.out_data (fifo_q)
	);

	// lines released whenever the frame is not in data phase
	assign io_out          = out_r;
	assign io_oe           = (st_r == ST_DATA && !s2_r.cs_n) ? 4'hf : 4'h0; // RL24
	assign mem_addr        = fa_r;
	assign xip_active      = xip_r;
	assign wrap_enabled    = wen_r;
	assign wrap_depth_code = wdep_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_last_cmd;
		sclk_rise && !cs_rise && !cs_fall && st_r == ST_CMD && last;
	endsequence
	sequence s_wrap_off;
		sclk_rise && st_r == ST_WRAPB && last && byte_in[WRAP_OFF_BIT];
	endsequence

	a_oe_cs_high: assert property (s2_r.cs_n |-> io_oe == 4'h0) // RL24
		else $error("data lines driven with chip select high");
	a_busy_ignore: assert property (s_last_cmd and busy // RL6
		|=> st_r == ST_IGNORE)
		else $error("read accepted while busy");
	a_wrap_off_code: assert property (s_wrap_off |=> !wrap_enabled) // RL11
		else $error("wrap code 1x did not disable wrap");
	a_addr_step: assert property (mem_req && mem_ready && !wact_r // RL2
		|=> mem_addr == $past(mem_addr) + 1'b1)
		else $error("fetch address did not advance by one");
	// every depth keeps the low three bits counting inside the block
	a_wrap_block: assert property (mem_req && mem_ready && wact_r // RL12
		|=> (mem_addr >> 6) == ($past(mem_addr) >> 6)
		&& mem_addr[2:0] == 3'($past(mem_addr[2:0]) + 3'h1))
		else $error("wrapped fetch left its block");
	a_xip_skip: assert property (cs_fall && xip_r && !busy // RL18
		|=> st_r == ST_ADDR && quad_r)
		else $error("continuous read did not skip the opcode");
	a_nibble_hi: assert property (sclk_fall && st_r == ST_DATA // RL1
		&& !half_r |=> io_out == $past(fifo_q[7:4]))
		else $error("high nibble not driven first");
	a_short_dummy: assert property (sclk_rise && st_r == ST_ADDR // RL8
		&& st_nxt == ST_DUMMY && op_r == OP_FOUR_LINE_READ_SHORT_DUMMY
		|=> dcnt_r == 4'h4)
		else $error("short dummy read not four clocks");
	a_xip_exit: assert property (cs_rise && ind_r && !keep_r // RL17
		|=> !xip_active ##1 !xip_active)
		else $error("continuous read kept after plain indicator");

endmodule : qrd_engine

// >>> qrd_pkg.sv
// Function
// [RL1] sample address on rise, drive nibbles on fall
// [RL2] read address steps per byte, rolls to zero
// [RL3] quad output read: serial address, 8 dummies
// [RL4] serial 4-line read: quad address, 6 dummies
// [RL5] quad command mode accepts 4-line read too
// [RL6] ignore quad reads while internal cycle busy
// [RL7] dummy count follows two configuration bits
// [RL8] E7h read uses four dummy clocks
// [RL9] burst wrap off after reset, sticky otherwise
// [RL10] host sets wrap with C0h plus code byte
// [RL11] codes 00h-03h give 8-64 bytes, 1xh off
// [RL12] wrap inside aligned block of selected depth
// [RL13] wrap only for EBh and E7h reads
// [RL14] wrap command in 8 serial or 2 quad clocks
// [RL15] continuous read only through EBh read
// [RL16] complementary indicator nibbles keep continuous read
// [RL17] matching indicator bits end continuous read later
// [RL18] continuous read skips opcode, starts with address
// [RL19] indicator then four dummies then data stream
// [RL20] host drives lines during indicator clocks
// [RL21] all-ones cycle forces continuous read off
// [RL22] controller reset abandons continuous read
// [RL23] host keeps indicator non-complementary when unwanted
// [RL24] data lines driven only in data phase
//
// Purpose: shared constants and types of the quad read engine
// Assumes: one system clock, link pins sampled through synchronisers
// Notes:   all opcodes and counts live here
package qrd_pkg;

	localparam logic [7:0] OP_QUAD_OUTPUT_READ = 8'h6b;
	localparam logic [7:0] OP_FOUR_LINE_IO_READ = 8'heb;
	localparam logic [7:0] OP_FOUR_LINE_READ_SHORT_DUMMY = 8'he7;
	localparam logic [7:0] OP_SET_BURST = 8'hc0;
	localparam logic [7:0] OP_MODE_RESET = 8'hff;

	localparam logic [4:0] SER_BYTE_LAST = 5'h07;
	localparam logic [4:0] QUAD_BYTE_LAST = 5'h01;
	localparam logic [4:0] SER_ADDR_LAST = 5'h17;
	localparam logic [4:0] QUAD_ADDR_LAST = 5'h05;
	localparam logic [4:0] IND_LAST = 5'h01;
	localparam logic [3:0] IND_CLOCKS = 4'h2;

	localparam logic [3:0] DUMMY_QUAD_OUTPUT = 4'h8;
	localparam logic [3:0] DUMMY_FOUR_LINE = 4'h6;
	localparam logic [3:0] DUMMY_SHORT = 4'h4;
	localparam logic [3:0] DUMMY_DC_01 = 4'h6;
	localparam logic [3:0] DUMMY_DC_10 = 4'h8;
	localparam logic [3:0] DUMMY_DC_11 = 4'ha;

	localparam int WRAP_OFF_BIT = 4;
	localparam logic [1:0] WRAP_RESET_CODE = 2'h0;

	typedef enum logic [7:0] {
		ST_IDLE   = 8'h01,
		ST_CMD    = 8'h02,
		ST_ADDR   = 8'h04,
		ST_IND    = 8'h08,
		ST_DUMMY  = 8'h10,
		ST_DATA   = 8'h20,
		ST_WRAPB  = 8'h40,
		ST_IGNORE = 8'h80
	} rd_state_t;

	typedef struct packed {
		logic       cs_n;
		logic       sclk;
		logic [3:0] io;
	} link_pins_t;

endpackage : qrd_pkg

// >>> qrd_fifo.sv
// Purpose: byte FIFO between array fetch and the nibble shifter
// Assumes: single clock, flush drops all contents at once
// Notes:   storage is a flop array, count gives honest full/empty
`timescale 1ns/1ns
module qrd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("fifo depth must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] head_r;
	logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             push, pop;

	assign in_ready  = (cnt_r != AW'(0) + (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = head_r;
	assign push      = in_valid && in_ready && !flush;
	assign pop       = out_valid && out_ready && !flush;

	// pointer and count update, flush wins
	always_comb begin
		wr_nxt  = wr_r + AW'(push);
		rd_nxt  = rd_r + AW'(pop);
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		if (flush) begin
			wr_nxt  = '0;
			rd_nxt  = '0;
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			wr_r  <= wr_nxt;
			rd_r  <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// data store has no reset, only written entries are read
	// head is registered; a word landing in the next head slot bypasses
	always_ff @(posedge clk) begin
		if (push)
			mem_r[wr_r] <= in_data;
		head_r <= (push && wr_r == rd_nxt) ? in_data : mem_r[rd_nxt];
	end

endmodule : qrd_fifo

// >>> host_link.sv
// Purpose: host controller model that drives the quad link
// Assumes: tasks are entered on a clk falling edge; 20 clk half period
// Notes:   released lines carry the inverse of the last value
`timescale 1ns/1ns
module host_link (
	input  wire logic       clk,
	input  wire logic [3:0] io_out,
	input  wire logic [3:0] io_oe,
	output logic            cs_n,
	output logic            sclk,
	output logic [3:0]      io_in
);
	logic [7:0] rx [0:7];
	logic [3:0] q;
	logic [3:0] qe;
	logic [3:0] oe_seen;
	logic       oe_bad;

	// idle link: deselected, clock parked low
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		io_in = 4'h0;
	end

	// ----------------------------------------
	// link cycles
	// ----------------------------------------
	// sample late in the low half, clear of the 2-3 clk output lag
	task automatic tick(input logic [3:0] v);
		sclk = 1'b0;
		io_in = v;
		repeat (20) @(negedge clk);
		qe = io_oe;
		q = (io_out & qe) | (~io_out & ~qe); // released lines read inverted
		oe_seen |= qe;
		sclk = 1'b1;
		repeat (20) @(negedge clk);
	endtask : tick

	// serial: msb first on line 0, upper lines carry junk
	task automatic put_byte(input logic [7:0] b, input logic quad);
		if (quad) begin
			tick(b[7:4]);
			tick(b[3:0]);
		end else begin
			for (int i = 7; i >= 0; i--)
				tick({3'b101, b[i]});
		end
	endtask : put_byte

	// deselect with sclk high, then stop the clock low
	task automatic close();
		cs_n = 1'b1;
		repeat (20) @(negedge clk);
		sclk = 1'b0;
		io_in = ~io_in;
		repeat (20) @(negedge clk);
	endtask : close

	// n bytes of w, msb first: wrap setting, mode reset
	task automatic cmd(input logic [31:0] w, input int n,
		input logic quad);
		cs_n = 1'b0;
		oe_seen = 4'h0;
		for (int i = 0; i < n; i++)
			put_byte(w[31-8*i -: 8], quad);
		close();
	endtask : cmd

	// read frame; om 0 skips the opcode, 1 serial, 2 quad
	task automatic frame(input logic [7:0] op, input int om,
		input logic aq, input logic [23:0] a, input logic ni,
		input logic [7:0] ind, input int nd, input int nb);
		cs_n = 1'b0;
		oe_seen = 4'h0;
		oe_bad = 1'b0;
		if (om != 0)
			put_byte(op, om == 2);
		for (int i = 0; i < 3; i++)
			put_byte(a[23-8*i -: 8], aq);
		if (ni)
			put_byte(ind, 1'b1);
		repeat (nd) begin
			tick(~io_in);
			oe_bad |= qe !== 4'h0;
		end
		for (int k = 0; k < nb; k++) begin
			tick(~io_in);
			rx[k][7:4] = q;
			oe_bad |= qe !== 4'hf;
			tick(~io_in);
			rx[k][3:0] = q;
			oe_bad |= qe !== 4'hf;
		end
		close();
	endtask : frame
endmodule : host_link

// >>> tb.sv
// Purpose: self-checking bench of the quad read engine
// Assumes: host model drives the link, array model answers here
// Notes:   array byte is a fixed function of its address
`timescale 1ns/1ns
module tb;
	import qrd_pkg::*;

	logic        clk, nrst, busy, qmode, dc_lo, dc_hi, cs_n, sclk;
	logic [3:0]  io_in, io_out, io_oe;
	logic        mem_req, mem_ready, mem_rvalid, took;
	logic [22:0] mem_addr, a_s, a_hold;
	logic [7:0]  mem_rdata;
	logic        xip_active, wrap_enabled;
	logic [1:0]  wrap_depth_code;
	int          wait_n, n_fail, comparisons;

	qrd_engine #(.ADDR_W(23), .FIFO_DEPTH(16)) i_qrd_engine (
		.clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe), .busy(busy),
		.quad_command_mode(qmode), .dummy_count_bit_lo(dc_lo),
		.dummy_count_bit_hi(dc_hi), .mem_req(mem_req),
		.mem_ready(mem_ready), .mem_addr(mem_addr),
		.mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
		.xip_active(xip_active), .wrap_enabled(wrap_enabled),
		.wrap_depth_code(wrap_depth_code));
	host_link i_host_link (.clk(clk), .io_out(io_out), .io_oe(io_oe),
		.cs_n(cs_n), .sclk(sclk), .io_in(io_in));

	// ----------------------------------------
	// clock, array model, helpers
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [7:0] mem_byte(input logic [22:0] a);
		return a[7:0] ^ a[22:15] ^ 8'h5a;
	endfunction : mem_byte

	// take on the edge, answer three cycles on; ready stalls every other
	always @(posedge clk) begin
		took = mem_req && mem_ready;
		a_s = mem_addr;
	end
	always @(negedge clk) begin
		mem_rvalid = 1'b0;
		mem_rdata = ~mem_rdata;
		if (took) begin
			a_hold = a_s;
			wait_n = 3;
		end else if (wait_n > 0) begin
			wait_n--;
			if (wait_n == 0) begin
				mem_rvalid = 1'b1;
				mem_rdata = mem_byte(a_hold);
			end
		end
		mem_ready = !mem_ready && wait_n == 0 && !mem_rvalid;
	end

	task automatic check(input string w, input logic [7:0] got,
		input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", w, exp, got);
		end
	endtask : check

	task automatic finish_test();
		if (n_fail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	task automatic do_reset();
		nrst = 1'b0;
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
	endtask : do_reset

	// ind[8] asks for indicator clocks; ws is the wrap size, 0 = none
	task automatic rd(input logic [7:0] op, input int om,
		input logic [23:0] a, input logic [8:0] ind, input int nd,
		input int nb, input int ws);
		logic [22:0] x;
		i_host_link.frame(op, om, op != 8'h6b, a, ind[8], ind[7:0],
			nd, nb);
		for (int k = 0; k < nb; k++) begin
			x = a[22:0] + 23'(k);
			if (ws > 0)
				x = (a[22:0] & ~23'(ws - 1)) | (x & 23'(ws - 1));
			check("byte", i_host_link.rx[k], mem_byte(x));
		end
		check("oe", 8'(i_host_link.oe_bad), 8'h0);
		check("oe idle", 8'(io_oe), 8'h0);
	endtask : rd

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_state();
		check("xip", 8'(xip_active), 8'h0);
		check("wrap", 8'(wrap_enabled), 8'h0);
		check("depth", 8'(wrap_depth_code), 8'h0);
	endtask : t_reset_state

	// every dummy setting; start below the top to see the roll-over
	task automatic t_quad_output();
		int nd [4] = '{8, 6, 8, 10};
		for (int c = 0; c < 4; c++) begin
			{dc_hi, dc_lo} = 2'(c);
			rd(8'h6b, 1, 24'h7ffffe, 9'h0, nd[c], 3, 0);
		end
		{dc_hi, dc_lo} = 2'b00;
	endtask : t_quad_output

	task automatic t_four_line();
		rd(8'heb, 1, 24'h123456, 9'h100, 4, 2, 0);
		rd(8'he7, 1, 24'h0abcde, 9'h0, 4, 2, 0);
		qmode = 1'b1;
		rd(8'heb, 2, 24'h5a5a50, 9'h1ff, 4, 2, 0);
		{dc_hi, dc_lo} = 2'b11;
		rd(8'heb, 2, 24'h000010, 9'h155, 8, 1, 0);
		{dc_hi, dc_lo} = 2'b00;
		qmode = 1'b0;
		check("xip", 8'(xip_active), 8'h0);
	endtask : t_four_line

	// a toggling indicator under busy must neither answer nor enter
	task automatic t_busy();
		busy = 1'b1;
		qmode = 1'b1;
		i_host_link.frame(8'heb, 2, 1'b1, 24'h100, 1'b1, 8'ha5, 4, 2);
		check("busy oe", 8'(i_host_link.oe_seen), 8'h0);
		check("busy xip", 8'(xip_active), 8'h0);
		busy = 1'b0;
		qmode = 1'b0;
	endtask : t_busy

	task automatic t_wrap();
		for (int c = 0; c < 4; c++) begin
			qmode = c[0];
			i_host_link.cmd({8'hc0, 6'h0, 2'(c), 16'h0}, 2, c[0]);
			check("wrap on", 8'(wrap_enabled), 8'h1);
			check("depth", 8'(wrap_depth_code), 8'(c));
		end
		rd(8'heb, 2, 24'h00013e, 9'h1ff, 4, 4, 64);
		qmode = 1'b0;
		i_host_link.cmd(32'hc0000000, 2, 1'b0);
		rd(8'he7, 1, 24'h000105, 9'h0, 4, 6, 8);
		rd(8'heb, 1, 24'h00010d, 9'h100, 4, 4, 8);
		rd(8'h6b, 1, 24'h000107, 9'h0, 8, 3, 0);
		check("wrap kept", 8'(wrap_enabled), 8'h1);
		i_host_link.cmd(32'hc01f0000, 2, 1'b0);
		check("wrap off", 8'(wrap_enabled), 8'h0);
		rd(8'he7, 1, 24'h000107, 9'h0, 4, 2, 0);
	endtask : t_wrap

	task automatic t_xip();
		rd(8'heb, 1, 24'h000200, 9'h1a5, 4, 2, 0);
		check("xip on", 8'(xip_active), 8'h1);
		rd(8'h00, 0, 24'h0003f0, 9'h10f, 4, 2, 0);
		check("xip kept", 8'(xip_active), 8'h1);
		rd(8'h00, 0, 24'h004000, 9'h1aa, 4, 1, 0);
		check("xip off", 8'(xip_active), 8'h0);
		rd(8'h6b, 1, 24'h000300, 9'h0, 8, 1, 0);
		qmode = 1'b1;
		rd(8'heb, 2, 24'h000400, 9'h15a, 4, 1, 0);
		i_host_link.cmd(32'hffffffff, 4, 1'b1);
		check("xip reset", 8'(xip_active), 8'h0);
		qmode = 1'b0;
		i_host_link.cmd(32'hc0020000, 2, 1'b0);
		rd(8'heb, 1, 24'h000500, 9'h1f0, 4, 1, 32);
		check("xip again", 8'(xip_active), 8'h1);
		do_reset();
		t_reset_state();
		rd(8'h6b, 1, 24'h000600, 9'h0, 8, 1, 0);
	endtask : t_xip

	// cap well above the ~30k cycles the scenarios need
	initial begin
		#320000;
		n_fail++;
		finish_test();
	end

	initial begin
		{nrst, busy, qmode, dc_lo, dc_hi} = 5'h0;
		{mem_ready, mem_rvalid, took} = 3'h0;
		mem_rdata = 8'h0;
		wait_n = 0;
		n_fail = 0;
		comparisons = 0;
		@(negedge clk);
		do_reset();
		t_reset_state();
		t_quad_output();
		t_four_line();
		t_busy();
		t_wrap();
		t_xip();
		finish_test();
	end
endmodule : tb
